// ---- rcf_consts.svh ----
// named constants of the rate-of-change-of-frequency decision block
// assumes a 100 MHz system clock and frequencies given in mHz
`ifndef RCF_CONSTS_SVH
`define RCF_CONSTS_SVH

`define RCF_CLK_PERIOD_NS 10
`define RCF_MS_NS         1000000
`define RCF_FILT_MS       100
`define RCF_THR_W         11
`define RCF_THR_MIN       (-500)
`define RCF_THR_MAX       500
`define RCF_THR_DEF       50
`define RCF_DLY_W         14
`define RCF_DLY_MIN       200
`define RCF_DLY_MAX       10000
`define RCF_DLY_DEF       200
`define RCF_ACCEPT_N      4
`define RCF_HIST_LAG      5
`define RCF_RATE_SCALE    50000
`define RCF_RATIO_KNEE    50
`define RCF_RATIO_HI      920
`define RCF_RATIO_LO      999
`define RCF_RATIO_DEN     1000
`define RCF_VMIN_DIV      10

`endif

// ---- rcf_pkg.sv ----
// types shared by the rate-of-change-of-frequency decision block
// assumes rcf_consts.svh holds the widths and counts
package rcf_pkg;
  typedef logic [16:0]        rcf_freq_t;
  typedef logic [2:0]         rcf_addr_t;
  typedef logic signed [47:0] rcf_wide_t;
  typedef logic [1:0]         rcf_cnt_t;
  typedef enum logic [1:0] {RCF_OFF, RCF_ONSET, RCF_PICKED} rcf_state_e;
endpackage

// ---- rcf_hist_if.sv ----
// carrier between the decision logic and its frequency history memory
// assumes one clock for both ends
`timescale 1ns/1ps
interface rcf_hist_if;
  import rcf_pkg::*;
  logic      wr_en;
  rcf_addr_t wr_addr;
  rcf_freq_t wr_data;
  rcf_addr_t rd_addr;
  rcf_freq_t rd_data;
  modport owner (output wr_en, wr_addr, wr_data, rd_addr, input rd_data);
  modport mem   (input wr_en, wr_addr, wr_data, rd_addr, output rd_data);
endinterface

// ---- rcf_hist_mem.sv ----
// eight-word history of accepted frequencies, registered read data
// assumes reads and writes come from the same clock domain
`timescale 1ns/1ps
module rcf_hist_mem
  import rcf_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  rcf_hist_if.mem  hist
);
  rcf_freq_t mem_q [8];
  rcf_freq_t rd_q;

  always_ff @(posedge clk_sys_i)
  begin
    if (hist.wr_en)
      mem_q[hist.wr_addr] <= hist.wr_data;
  end

  // a read of the slot being written returns the old word
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      rd_q <= '0;
    else
      rd_q <= mem_q[hist.rd_addr];
  end

  assign hist.rd_data = rd_q;
endmodule

// ---- rcf_top.sv ----
// decision logic of a rate-of-change-of-frequency protection element
// assumes per-period frequency measurements and settings come from
// logic on clk_sys_i, so no input is synchronised
`timescale 1ns/1ps
`include "rcf_consts.svh"
// Notes on behaviour
// - signed threshold -5.00..5.00 Hz/s in 0.01 steps, default 0.50
// - trip delay 200..10000 ms, 1 ms steps, default 200, incl. algorithm time
// - pickup-only option keeps trip off; default allows trip
// - blocking input forces pickup and trip off
// - pickup when rate beyond threshold, enabled and unblocked
// - trip once the condition lasted the delay, unless pickup-only or blocked
// - an event with the new value on every pickup or trip change
// - delay timed from onset of the faulty rate, not from pickup
// - drop below 0.92 of threshold above 0.5 Hz/s, else 0.999
// - nothing issued while voltage is at or below 10% of rated
// - rate is frequency now minus five periods back, filtered 100 ms
// - frequency accepted after four valid, zeroed after four invalid
module rcf_top
  import rcf_pkg::*;
#(
  parameter int unsigned MS_CYCLES = `RCF_MS_NS / `RCF_CLK_PERIOD_NS
)
(
  input  wire logic                        clk_sys_i,
  input  wire logic                        rst_n_i,
  input  wire logic                        cfg_load_i,
  input  wire logic                        operation_en_i,
  input  wire logic                        pickup_only_i,
  input  wire logic signed [`RCF_THR_W-1:0] rate_threshold_setting_i,
  input  wire logic [`RCF_DLY_W-1:0]       trip_delay_ms_i,
  input  wire logic                        protection_block_in_i,
  input  wire logic                        meas_strobe_i,
  input  wire logic                        meas_ok_i,
  input  wire logic [16:0]                 freq_mhz_i,
  input  wire logic [15:0]                 volt_mag_i,
  input  wire logic [15:0]                 volt_rated_i,
  output logic                             general_pickup_out_o,
  output logic                             general_trip_out_o,
  output logic                             pickup_event_o,
  output logic                             trip_event_o,
  output logic [16:0]                      freq_accepted_o
);
  function automatic rcf_wide_t mag(input rcf_wide_t v);
    mag = v[47] ? -v : v;
  endfunction

  rcf_hist_if hist ();
  rcf_hist_mem u_mem (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .hist(hist));

  // settings, held with their defaults until software loads them
  logic                         op_en_q, pu_only_q;
  logic signed [`RCF_THR_W-1:0] thr_q;
  logic [`RCF_DLY_W-1:0]        dly_q;
  wire logic signed [`RCF_THR_W-1:0] thr_lo = `RCF_THR_W'(`RCF_THR_MIN);
  wire logic signed [`RCF_THR_W-1:0] thr_hi = `RCF_THR_W'(`RCF_THR_MAX);
  wire logic [`RCF_DLY_W-1:0] dly_lo = `RCF_DLY_W'(`RCF_DLY_MIN);
  wire logic [`RCF_DLY_W-1:0] dly_hi = `RCF_DLY_W'(`RCF_DLY_MAX);
  wire logic signed [`RCF_THR_W-1:0] thr_clip =
    (rate_threshold_setting_i < thr_lo) ? thr_lo :
    (rate_threshold_setting_i > thr_hi) ? thr_hi :
    rate_threshold_setting_i;
  wire logic [`RCF_DLY_W-1:0] dly_clip =
    (trip_delay_ms_i < dly_lo) ? dly_lo :
    (trip_delay_ms_i > dly_hi) ? dly_hi : trip_delay_ms_i;

  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      op_en_q   <= 1'b0;
      pu_only_q <= 1'b0;
      thr_q     <= `RCF_THR_W'(`RCF_THR_DEF);
      dly_q     <= `RCF_DLY_W'(`RCF_DLY_DEF);
    end
    else if (cfg_load_i)
    begin
      op_en_q   <= operation_en_i;
      pu_only_q <= pickup_only_i;
      thr_q     <= thr_clip;
      dly_q     <= dly_clip;
    end
  end

  // millisecond enable pulse
  logic [16:0] tick_cnt_q;
  wire logic ms_tick = (tick_cnt_q == 17'(MS_CYCLES - 1));
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      tick_cnt_q <= '0;
    else
      tick_cnt_q <= ms_tick ? '0 : tick_cnt_q + 17'd1;
  end

  // frequency acceptance and history
  rcf_cnt_t  val_cnt_q, inv_cnt_q;
  rcf_freq_t freq_q;
  rcf_addr_t wptr_q;
  logic [2:0] fill_q;
  logic       upd_q, upd_ok_q;
  wire logic  good = meas_strobe_i & meas_ok_i;
  wire logic  bad  = meas_strobe_i & ~meas_ok_i;
  wire logic  accept = good & (val_cnt_q == 2'(`RCF_ACCEPT_N - 1));
  wire logic  lose   = bad & (inv_cnt_q == 2'(`RCF_ACCEPT_N - 1));
  wire logic  hist_full = (fill_q == 3'(`RCF_HIST_LAG));

  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      val_cnt_q <= '0;
      inv_cnt_q <= '0;
      freq_q    <= '0;
      wptr_q    <= '0;
      fill_q    <= '0;
      upd_q     <= 1'b0;
      upd_ok_q  <= 1'b0;
    end
    else
    begin
      upd_q <= accept;
      if (good)
      begin
        inv_cnt_q <= '0;
        if (!accept)
          val_cnt_q <= val_cnt_q + 2'd1;
      end
      if (bad)
      begin
        val_cnt_q <= '0;
        if (!lose)
          inv_cnt_q <= inv_cnt_q + 2'd1;
      end
      if (accept)
      begin
        freq_q   <= freq_mhz_i;
        wptr_q   <= wptr_q + 3'd1;
        upd_ok_q <= hist_full;
        if (!hist_full)
          fill_q <= fill_q + 3'd1;
      end
      if (lose)
      begin
        freq_q   <= '0;
        fill_q   <= '0;
        upd_ok_q <= 1'b0;
      end
    end
  end

  assign hist.wr_en   = accept;
  assign hist.wr_addr = wptr_q;
  assign hist.wr_data = freq_mhz_i;
  assign hist.rd_addr = 3'(wptr_q - 3'(`RCF_HIST_LAG));

  // rate scaled so that one threshold step equals RATE_SCALE units
  rcf_wide_t rate_q;
  logic      rate_ok_q;
  wire rcf_wide_t diff = 48'(signed'({1'b0, freq_q}))
                       - 48'(signed'({1'b0, hist.rd_data}));
  wire rcf_wide_t prod = 48'(diff * 48'(signed'({1'b0, freq_q})));
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rate_q    <= '0;
      rate_ok_q <= 1'b0;
    end
    else if (upd_q)
    begin
      rate_q    <= prod;
      rate_ok_q <= upd_ok_q;
    end
    else if (lose)
      rate_ok_q <= 1'b0;
  end

  // comparator with direction and hysteresis
  wire rcf_wide_t thr_s =
    48'(48'(signed'(thr_q)) * 48'(`RCF_RATE_SCALE));
  wire rcf_wide_t thr_mag = mag(thr_s);
  wire rcf_wide_t dir_rate = thr_q[`RCF_THR_W-1] ? -rate_q : rate_q;
  wire logic knee = mag(48'(signed'(thr_q))) > 48'(`RCF_RATIO_KNEE);
  wire rcf_wide_t ratio = knee ? 48'(`RCF_RATIO_HI) : 48'(`RCF_RATIO_LO);
  wire logic pick_cmp = rate_ok_q & (dir_rate > thr_mag);
  wire logic drop_cmp = ~rate_ok_q
    | (48'(dir_rate * 48'(`RCF_RATIO_DEN)) < 48'(ratio * thr_mag));
  wire logic volt_ok =
    (20'(volt_mag_i) * 20'(`RCF_VMIN_DIV)) > 20'(volt_rated_i);
  wire logic active = op_en_q & ~protection_block_in_i & volt_ok;

  // raw fault, its 100 ms filter, and the delay timer from onset
  rcf_state_e st_q, st_d;
  logic       raw_q, filt_q;
  logic [6:0] filt_cnt_q;
  logic [`RCF_DLY_W-1:0] ms_cnt_q;
  wire logic raw_d = active & (raw_q ? ~drop_cmp : pick_cmp);
  wire logic filt_end = ms_tick & (filt_cnt_q == 7'(`RCF_FILT_MS - 1));
  wire logic timer_full = (ms_cnt_q == '1);

  always_comb
  begin
    st_d = st_q;
    unique case (st_q)
      RCF_OFF:    if (raw_q) st_d = RCF_ONSET;
      RCF_ONSET:  if (!raw_q) st_d = RCF_OFF;
                  else if (filt_end) st_d = RCF_PICKED;
      RCF_PICKED: if (raw_q) st_d = RCF_PICKED;
                  else if (filt_end) st_d = RCF_OFF;
    endcase
    if (!active)
      st_d = RCF_OFF;
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      st_q       <= RCF_OFF;
      raw_q      <= 1'b0;
      filt_cnt_q <= '0;
      ms_cnt_q   <= '0;
    end
    else
    begin
      st_q  <= st_d;
      raw_q <= raw_d;
      if (!active || (raw_q == filt_q) || filt_end)
        filt_cnt_q <= '0;
      else if (ms_tick)
        filt_cnt_q <= filt_cnt_q + 7'd1;
      if (!active || (st_q == RCF_OFF && !raw_q))
        ms_cnt_q <= '0;
      else if (ms_tick && !timer_full)
        ms_cnt_q <= ms_cnt_q + `RCF_DLY_W'(1);
    end
  end
  assign filt_q = (st_q == RCF_PICKED);

  // outputs and change events
  wire logic pu_d = active & filt_q;
  wire logic tr_d = pu_d & ~pu_only_q & (ms_cnt_q >= dly_q);
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      general_pickup_out_o <= 1'b0;
      general_trip_out_o   <= 1'b0;
      pickup_event_o       <= 1'b0;
      trip_event_o         <= 1'b0;
    end
    else
    begin
      general_pickup_out_o <= pu_d;
      general_trip_out_o   <= tr_d;
      pickup_event_o <= pu_d ^ general_pickup_out_o;
      trip_event_o   <= tr_d ^ general_trip_out_o;
    end
  end
  assign freq_accepted_o = freq_q;

  property p_block_clears;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    protection_block_in_i |=> !general_pickup_out_o && !general_trip_out_o;
  endproperty
  a_block_clears: assert property (p_block_clears)
    else $error("blocked but pickup or trip asserted");

  property p_pickup_only;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    pu_only_q |=> !general_trip_out_o;
  endproperty
  a_pickup_only: assert property (p_pickup_only)
    else $error("trip asserted in pickup-only mode");

  property p_off_clears;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    !op_en_q |=> !general_pickup_out_o && !general_trip_out_o
                 && ms_cnt_q == '0;
  endproperty
  a_off_clears: assert property (p_off_clears)
    else $error("disabled but outputs or timer not cleared");

  property p_trip_with_pickup;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    general_trip_out_o |-> general_pickup_out_o;
  endproperty
  a_trip_with_pickup: assert property (p_trip_with_pickup)
    else $error("trip without pickup");

  property p_trip_time;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    $rose(general_trip_out_o) |-> $past(ms_cnt_q) >= $past(dly_q);
  endproperty
  a_trip_time: assert property (p_trip_time)
    else $error("trip before the delay from onset");

  property p_event_on_change;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    ($changed(general_pickup_out_o) |-> pickup_event_o)
    and ($changed(general_trip_out_o) |-> trip_event_o);
  endproperty
  a_event_on_change: assert property (p_event_on_change)
    else $error("output change without event");

  property p_low_voltage;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    !volt_ok |=> !general_pickup_out_o;
  endproperty
  a_low_voltage: assert property (p_low_voltage)
    else $error("pickup at low voltage");

  property p_filter;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    $rose(filt_q) |-> $past(raw_q)
      && $past(filt_cnt_q) == 7'(`RCF_FILT_MS - 1);
  endproperty
  a_filter: assert property (p_filter)
    else $error("pickup filter shorter than its delay");

  property p_accept;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    accept |=> freq_q == $past(freq_mhz_i) ##1 upd_q == 1'b0;
  endproperty
  a_accept: assert property (p_accept)
    else $error("accepted frequency not taken");
endmodule

// ---- rcf_meas_src.sv ----
// stand-in for the frequency measurement front end
// assumes the bench drives its controls at the falling edge
`timescale 1ns/1ps
module rcf_meas_src
  import rcf_pkg::*;
(
  input  wire logic               clk_sys_i,
  input  wire logic               run_i,
  input  wire logic               ok_i,
  input  wire logic signed [15:0] step_i,
  input  wire logic [16:0]        base_i,
  output logic                    meas_strobe_o,
  output logic                    meas_ok_o,
  output rcf_freq_t               freq_o
);
  int f = 0;
  int n = 0;

  initial
  begin
    meas_strobe_o = 1'b0;
    meas_ok_o     = 1'b0;
    freq_o        = 17'h00000;
  end

  // lines toggle between strobes so a stale value is never mistaken;
  // an invalid strobe restarts the ramp from base_i, keeping f in range
  always @(negedge clk_sys_i)
  begin
    if (run_i && n == 19)
    begin
      n = 0;
      f = ok_i ? f + int'(step_i) : int'(base_i);
      meas_strobe_o <= 1'b1;
      meas_ok_o     <= ok_i;
      freq_o        <= f[16:0];
    end
    else
    begin
      n = run_i ? n + 1 : 0;
      if (!run_i)
        f = int'(base_i);
      meas_strobe_o <= 1'b0;
      meas_ok_o     <= ~meas_ok_o;
      freq_o        <= ~freq_o;
    end
  end
endmodule

// ---- testbench.sv ----
// self-checking bench of the rate-of-change decision block
// assumes MS_CYCLES of 10, so one ms is ten clocks
`timescale 1ns/1ps
`include "rcf_consts.svh"
module testbench
  import rcf_pkg::*;
;
  logic                         clk_sys_i;
  logic                         rst_n_i = 1'b0;
  logic                         cfg_load_i = 1'b0;
  logic                         op_en = 1'b0;
  logic                         po_en = 1'b0;
  logic signed [`RCF_THR_W-1:0] thr_set = 11'h000;
  logic [`RCF_DLY_W-1:0]        dly_set = 14'h0000;
  logic                         blk = 1'b0;
  logic                         run = 1'b0;
  logic                         ok = 1'b1;
  logic signed [15:0]           step = 16'h0005;
  logic [15:0]                  vmag = 16'h2000;
  logic [16:0]                  base = 17'h0b3b0;
  logic                         stb;
  logic                         mok;
  rcf_freq_t                    freq;
  rcf_freq_t                    acc_o;
  logic                         pk;
  logic                         tr;
  logic                         pk_ev;
  logic                         tr_ev;
  logic                         flt = 1'b0;
  logic                         lpk = 1'b0;
  logic                         ltr = 1'b0;
  int                           n_mismatch = 0;
  int                           checks = 0;
  int                           cyc = 0;
  int                           nok = 0;
  int                           nbad = 0;
  int                           thr = 50;
  int                           acc = 0;
  int                           t;
  int                           seed = 32'hdf09;
  longint                       hist[$];
  longint                       r;
  longint                       a;

  initial
  begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end

  always @(posedge clk_sys_i) cyc++;

  rcf_meas_src src (.clk_sys_i(clk_sys_i), .run_i(run), .ok_i(ok),
    .step_i(step), .base_i(base), .meas_strobe_o(stb), .meas_ok_o(mok),
    .freq_o(freq));

  rcf_top #(.MS_CYCLES(10)) dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .cfg_load_i(cfg_load_i), .operation_en_i(op_en), .pickup_only_i(po_en),
    .rate_threshold_setting_i(thr_set), .trip_delay_ms_i(dly_set),
    .protection_block_in_i(blk), .meas_strobe_i(stb), .meas_ok_i(mok),
    .freq_mhz_i(freq), .volt_mag_i(vmag), .volt_rated_i(16'h1000),
    .general_pickup_out_o(pk), .general_trip_out_o(tr),
    .pickup_event_o(pk_ev), .trip_event_o(tr_ev), .freq_accepted_o(acc_o));

  task automatic chk(input rcf_freq_t seen, input rcf_freq_t exp);
    checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task finish_test;
    if (n_mismatch == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // reference model of acceptance, rate and hysteresis
  always @(posedge clk_sys_i)
    if (rst_n_i && stb)
    begin
      // once three in a row are seen, every further one is taken
      if (mok)
      begin
        nbad = 0;
        if (nok < 3)
          nok++;
        else
        begin
          acc = freq;
          hist.push_back(acc);
          if (hist.size() > 6)
            void'(hist.pop_front());
        end
      end
      else
      begin
        nok = 0;
        if (nbad < 3)
          nbad++;
        else
        begin
          acc = 0;
          hist.delete();
        end
      end
      if (hist.size() < 6)
        flt = 1'b0;
      else
      begin
        r = (hist[$] - hist[$-5]) * hist[$];
        r = (thr < 0) ? -r : r;
        a = (thr < 0) ? -thr : thr;
        flt = flt ? (r * 1000 >= (a > 50 ? 920 : 999) * a * 50000)
                  : (r > a * 50000);
      end
      @(negedge clk_sys_i);
      @(negedge clk_sys_i);
      chk(acc_o, acc[16:0]);
    end

  always @(negedge clk_sys_i)
    if (rst_n_i)
    begin
      chk(pk, pk_ev ? !lpk : lpk);
      chk(tr, tr_ev ? !ltr : ltr);
      lpk = pk;
      ltr = tr;
    end

  task wait_to(input int c);
    while (cyc < c)
      @(negedge clk_sys_i);
  endtask

  task cfg(input logic o, input logic p, input int th, input int d);
    op_en = o;
    po_en = p;
    thr_set = th[10:0];
    dly_set = d[13:0];
    cfg_load_i = 1'b1;
    thr = (th > 500) ? 500 : ((th < -500) ? -500 : th);
    @(negedge clk_sys_i);
    cfg_load_i = 1'b0;
    @(negedge clk_sys_i);
  endtask

  // switching off also forces a loss so the history restarts
  task prep;
    cfg(1'b0, 1'b0, 50, 200);
    chk(pk, 1'b0);
    chk(tr, 1'b0);
    ok = 1'b0;
    wait_to(cyc + 100);
    ok = 1'b1;
  endtask

  task run_case(input int th, input int d, input logic p, input int s,
                input logic [15:0] v);
    prep();
    vmag = v;
    step = s[15:0];
    cfg(1'b1, p, th, d);
    t = cyc + 700;
    while (!flt && cyc < t)
      @(negedge clk_sys_i);
    t = cyc;
    d = (d < 200 ? 200 : d) * 10;
    wait_to(t + 950);
    chk(pk, 1'b0);
    wait_to(t + 1060);
    chk(pk, flt && int'(v) * 10 > 4096);
    wait_to(t + d - 50);
    chk(tr, 1'b0);
    wait_to(t + d + 60);
    chk(tr, flt && int'(v) * 10 > 4096 && !p);
  endtask

  initial
  begin
    base = 17'(46000 + ($random(seed) & 2047));
    repeat (5) @(negedge clk_sys_i);
    rst_n_i = 1'b1;
    run = 1'b1;
    wait_to(1500);
    chk(pk, 1'b0);
    prep();
    // pick well above, then hold inside the hysteresis band, then drop
    step = 16'sd30;
    cfg(1'b1, 1'b0, 100, 200);
    wait_to(cyc + 1800);
    chk(pk, flt);
    step = 16'sd20;
    wait_to(cyc + 2000);
    chk(pk, flt);
    step = 16'sd8;
    wait_to(cyc + 2000);
    chk(pk, flt);
    run_case(50, 100, 1'b0, 20, 16'h019a);
    blk = 1'b1;
    @(negedge clk_sys_i);
    chk(pk, 1'b0);
    chk(tr, 1'b0);
    blk = 1'b0;
    run_case(50, 300, 1'b1, 20, 16'h2000);
    run_case(-50, 200, 1'b0, -20, 16'h2000);
    run_case(-50, 200, 1'b0, 20, 16'h2000);
    run_case(50, 200, 1'b0, 20, 16'h0199);
    run_case(50, 200, 1'b0, 1, 16'h2000);
    finish_test();
  end

  initial
  begin
    #600000;
    n_mismatch++;
    finish_test();
  end
endmodule
